//--- hw/hspc_pkg.sv
// Package of constants for the high speed pulse counter
package hspc_pkg;

    // ------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] HSPC_OFF_CTRL   = 8'h00;
    localparam logic [7:0] HSPC_OFF_TARGET = 8'h04;
    localparam logic [7:0] HSPC_OFF_COUNT  = 8'h08;
    localparam logic [7:0] HSPC_OFF_STATUS = 8'h0C;
    localparam logic [7:0] HSPC_OFF_MASK   = 8'h10;
    localparam logic [7:0] HSPC_OFF_INPUTS = 8'h14;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int HSPC_CTRL_ENABLE = 0;
    localparam int HSPC_CTRL_START  = 1;
    localparam int HSPC_ST_DONE     = 0;
    localparam int HSPC_ST_FAULT    = 1;
    localparam int HSPC_IN_PULSE    = 0;
    localparam int HSPC_IN_RESET    = 1;
    localparam int HSPC_EVT_W       = 2;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [1:0]  HSPC_CTRL_RST   = 2'h0;
    localparam logic [15:0] HSPC_TARGET_RST = 16'h0000;
    localparam logic [15:0] HSPC_COUNT_RST  = 16'h0000;
    localparam logic [1:0]  HSPC_EVT_RST    = 2'h0;

    // ------------------------------------------------------------
    // Timing: input filter for ordinary use (1 kHz, 500 us minimum)
    // ------------------------------------------------------------
    localparam int HSPC_CLK_HZ       = 50_000_000;
    localparam int HSPC_PLAIN_MIN_US = 500;
    localparam int HSPC_PLAIN_CYC    =
        (HSPC_PLAIN_MIN_US * (HSPC_CLK_HZ / 1_000_000));

endpackage

//--- hw/hspc_counter.sv
// High speed BCD pulse counter with AHB-Lite register slave
//
// Functional notes
// - Count pulses come from input bit 0000, hard reset from bit 0001.
// - Count starts at 0000, incrementing on each pulse rising edge.
// - Increment only while start gate is on and hard reset is off.
// - On reaching target, completion flag is high exactly one cycle.
// - On reaching target the count returns to zero by itself.
// - Target 0000 means terminal count 10,000 pulses.
// - Rising edge of hard reset clears the count.
// - Count held at zero while reset on; resumes from zero after.
// - With start gate off the count stays unchanged despite pulses.
// - Count is not cleared by interlocks or power interruptions; hresetn clears it to 0000.
// - Non-BCD target sets fault flag 0311; counter still runs.
// - Unused counter: dedicated inputs are plain inputs, up to 1 kHz.
//
// The AHB-Lite interface to the registers and the placing of the registers were decided locally.
module hspc_counter
    import hspc_pkg::*;
#(
    parameter int PLAIN_CYC = HSPC_PLAIN_CYC
) (
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [7:0]  haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Dedicated input pins (bit 0000 and bit 0001)
    input  wire logic        count_pulse_in,
    input  wire logic        hard_reset_in,
    // Counter outputs
    output logic             completion_flag,
    output logic             fault_flag,
    output logic      [1:0]  plain_inputs,
    output logic             irq
);
    import hspc_pkg::*;

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    function automatic logic is_bcd(input logic [15:0] v);
        logic ok;
        ok = 1'b1;
        for (int i = 0; i < 4; i++) begin
            if (v[i*4 +: 4] > 4'h9) begin
                ok = 1'b0;
            end
        end
        return ok;
    endfunction

    // BCD increment with ripple carry; 9999 wraps to 0000
    function automatic logic [15:0] bcd_inc(input logic [15:0] v);
        logic [15:0] r;
        logic        c;
        r = v;
        c = 1'b1;
        for (int i = 0; i < 4; i++) begin
            if (c) begin
                if (v[i*4 +: 4] >= 4'h9) begin
                    r[i*4 +: 4] = 4'h0;
                end else begin
                    r[i*4 +: 4] = v[i*4 +: 4] + 4'h1;
                    c = 1'b0;
                end
            end
        end
        return r;
    endfunction

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    // Both pins are asynchronous to hclk: two flops before any logic
    // Prev resets low, the pins' idle level, so no false edge follows reset
    logic [1:0] pin_meta;
    logic [1:0] pin_sync;
    logic [1:0] pin_prev;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_meta <= 2'h0;
            pin_sync <= 2'h0;
            pin_prev <= 2'h0;
        end else begin
            pin_meta <= {hard_reset_in, count_pulse_in};
            pin_sync <= pin_meta;
            pin_prev <= pin_sync;
        end
    end

    logic pulse_rise;
    logic rst_level;
    logic rst_rise;
    assign pulse_rise = pin_sync[HSPC_IN_PULSE] & ~pin_prev[HSPC_IN_PULSE];
    assign rst_level  = pin_sync[HSPC_IN_RESET];
    assign rst_rise   = rst_level & ~pin_prev[HSPC_IN_RESET];

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [1:0]  ctrl;
    logic [15:0] preset_target;
    logic [15:0] present_count;
    logic [1:0]  status;
    logic [1:0]  mask;
    logic [1:0]  plain_q;
    logic        done_q;
    logic [31:0] filt_cnt;

    logic [1:0]  next_ctrl;
    logic [15:0] next_preset_target;
    logic [15:0] next_present_count;
    logic [1:0]  next_status;
    logic [1:0]  next_mask;
    logic [1:0]  next_plain_q;
    logic        next_done_q;
    logic [31:0] next_filt_cnt;

    // AHB address phase capture
    logic       wr_pend;
    logic [7:0] wr_addr;
    logic       next_wr_pend;
    logic [7:0] next_wr_addr;
    logic [31:0] next_hrdata;

    logic addr_ok;
    assign addr_ok = hsel & hready & htrans[1];

    logic counter_on;
    assign counter_on = ctrl[HSPC_CTRL_ENABLE];

    // ------------------------------------------------------------
    // Counting logic
    // ------------------------------------------------------------
    logic        at_target;
    logic [15:0] inc_val;
    logic [1:0]  evt;
    logic [1:0]  w1c;

    always_comb begin
        inc_val = bcd_inc(present_count);
        // Target 0000 completes on the wrap from 9999
        at_target = (inc_val == preset_target);
        next_present_count = present_count;
        next_done_q = 1'b0;
        if (counter_on) begin
            if (rst_rise || rst_level) begin
                next_present_count = HSPC_COUNT_RST;
            end else if (ctrl[HSPC_CTRL_START] && pulse_rise) begin
                if (at_target) begin
                    next_present_count = HSPC_COUNT_RST;
                    next_done_q = 1'b1;
                end else begin
                    next_present_count = inc_val;
                end
            end
            // Start off: count held as is
        end
    end

    // ------------------------------------------------------------
    // Plain input filter
    // ------------------------------------------------------------
    // A level must stand PLAIN_CYC cycles before it is shown; this
    // keeps contact bounce out at the price of a slow response.
    always_comb begin
        // Dedicated inputs as ordinary filtered inputs when unused
        next_plain_q  = plain_q;
        next_filt_cnt = filt_cnt;
        if (counter_on) begin
            next_plain_q  = 2'h0;
            next_filt_cnt = 32'h0000_0000;
        end else if (pin_sync != plain_q) begin
            if (filt_cnt >= 32'(PLAIN_CYC - 1)) begin
                next_plain_q  = pin_sync;
                next_filt_cnt = 32'h0000_0000;
            end else begin
                next_filt_cnt = filt_cnt + 32'h0000_0001;
            end
        end else begin
            next_filt_cnt = 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------
    // Bus slave and status
    // ------------------------------------------------------------
    always_comb begin
        next_wr_pend = addr_ok & hwrite;
        next_wr_addr = addr_ok ? haddr : wr_addr;
        next_ctrl    = ctrl;
        next_preset_target = preset_target;
        next_mask    = mask;
        w1c          = 2'h0;
        if (wr_pend) begin
            if (wr_addr == HSPC_OFF_CTRL) begin
                next_ctrl = hwdata[1:0];
            end else if (wr_addr == HSPC_OFF_TARGET) begin
                next_preset_target = hwdata[15:0];
            end else if (wr_addr == HSPC_OFF_STATUS) begin
                w1c = hwdata[1:0];
            end else if (wr_addr == HSPC_OFF_MASK) begin
                next_mask = hwdata[1:0];
            end
        end
        evt = 2'h0;
        evt[HSPC_ST_DONE]  = done_q;
        evt[HSPC_ST_FAULT] = counter_on & ~is_bcd(preset_target);
        // Set wins over a write-one clear in the same cycle
        next_status = (status & ~w1c) | evt;
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    // Chosen in the address phase and registered, so it stands
    // through the whole data phase with no wait state.
    always_comb begin
        next_hrdata = 32'h0000_0000;
        if (addr_ok && !hwrite) begin
            if (haddr == HSPC_OFF_CTRL) begin
                next_hrdata = {30'h0, ctrl};
            end else if (haddr == HSPC_OFF_TARGET) begin
                next_hrdata = {16'h0, preset_target};
            end else if (haddr == HSPC_OFF_COUNT) begin
                next_hrdata = {16'h0, present_count};
            end else if (haddr == HSPC_OFF_STATUS) begin
                next_hrdata = {30'h0, status};
            end else if (haddr == HSPC_OFF_MASK) begin
                next_hrdata = {30'h0, mask};
            end else if (haddr == HSPC_OFF_INPUTS) begin
                next_hrdata = {30'h0, plain_q};
            end
        end
    end

    // ------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------
    // hresetn clears the count here; the hard reset pin and reaching target also clear it via next_present_count
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            present_count <= HSPC_COUNT_RST;
            done_q        <= 1'b0;
        end else begin
            present_count <= next_present_count;
            done_q        <= next_done_q;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            plain_q       <= 2'h0;
            filt_cnt      <= 32'h0000_0000;
        end else begin
            plain_q       <= next_plain_q;
            filt_cnt      <= next_filt_cnt;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl          <= HSPC_CTRL_RST;
            preset_target <= HSPC_TARGET_RST;
            status        <= HSPC_EVT_RST;
            mask          <= HSPC_EVT_RST;
            wr_pend       <= 1'b0;
            wr_addr       <= 8'h00;
        end else begin
            ctrl          <= next_ctrl;
            preset_target <= next_preset_target;
            status        <= next_status;
            mask          <= next_mask;
            wr_pend       <= next_wr_pend;
            wr_addr       <= next_wr_addr;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata        <= 32'h0000_0000;
        end else begin
            hrdata        <= next_hrdata;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Every access is answered at once: no wait states, always OKAY
    assign hreadyout       = 1'b1;
    assign hresp           = 1'b0;
    assign completion_flag = done_q;
    assign fault_flag      = counter_on & ~is_bcd(preset_target);
    assign plain_inputs    = plain_q;
    assign irq             = |(status & mask);

endmodule

//--- testbench/hspc_counter_monitor.sv
// Port checks for the pulse counter
module hspc_counter_monitor (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        count_pulse_in,
    input wire logic        hard_reset_in,
    input wire logic        completion_flag,
    input wire logic        fault_flag,
    input wire logic [1:0]  plain_inputs
);
    timeunit 1ns;
    timeprecision 1ns;
    logic rd_ph;
    logic wr_ph;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Data phase trackers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_ph <= 1'b0;
            wr_ph <= 1'b0;
        end else begin
            rd_ph <= hsel & hready & htrans[1] & !hwrite;
            wr_ph <= hsel & hready & htrans[1] & hwrite;
        end
    end
    sequence s_pin_low;
        !count_pulse_in [*8];
    endsequence
    sequence s_rst_held;
        hard_reset_in [*6];
    endsequence
    AST_READY: assert property (hreadyout) else $error("wait state");
    AST_OKAY: assert property (!hresp) else $error("bad response");
    AST_RDATA: assert property (!rd_ph |-> hrdata == 32'h0000_0000)
        else $error("read data outside data phase");
    AST_DONE_ONE: assert property (completion_flag |=> !completion_flag)
        else $error("completion longer than one cycle");
    AST_NO_PULSE: assert property (s_pin_low |-> !completion_flag)
        else $error("completion without pulse");
    AST_HRST_HOLD: assert property (s_rst_held |-> !completion_flag)
        else $error("completion under hard reset");
    AST_FAULT_MODE: assert property (
        fault_flag && $past(fault_flag) |-> plain_inputs == 2'b00)
        else $error("plain inputs live in counter mode");
    AST_DONE_MODE: assert property (
        completion_flag |-> plain_inputs == 2'b00)
        else $error("plain inputs live while counting");
    AST_FAULT_WR: assert property ($changed(fault_flag) |-> $past(wr_ph))
        else $error("fault flag moved without write");
endmodule

bind hspc_counter hspc_counter_monitor u_mon (.hclk, .hresetn, .hsel,
    .htrans, .hwrite, .hready, .hrdata, .hreadyout, .hresp,
    .count_pulse_in, .hard_reset_in, .completion_flag, .fault_flag,
    .plain_inputs);

//--- testbench/hspc_pulse_src.sv
// Pulse source and hard reset switch on the counter pins
module hspc_pulse_src (
    input  wire logic hclk,
    output logic      count_pulse_in,
    output logic      hard_reset_in
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        count_pulse_in = 1'b0;
        hard_reset_in  = 1'b0;
    end
    // Two high, two low; tail lets the pin pipeline drain
    task pulses(input int n);
        repeat (n) begin
            count_pulse_in <= 1'b1;
            repeat (2) @(posedge hclk);
            count_pulse_in <= 1'b0;
            repeat (2) @(posedge hclk);
        end
        repeat (6) @(posedge hclk);
    endtask
    // Drives the pulse pin and the reset pin together, then holds them 8 cycles
    task pins(input logic p, input logic r);
        count_pulse_in <= p;
        hard_reset_in  <= r;
        repeat (8) @(posedge hclk);
    endtask
endmodule

//--- testbench/test_high_speed_pulse_counter.sv
// Self-checking bench for the pulse counter
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin \
    num_errors++; $display("Error %s exp %h got %h", nm, e, g); end end
module test_high_speed_pulse_counter import hspc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic [7:0]  haddr;
    logic [1:0]  htrans, plain_inputs;
    logic [2:0]  hsize;
    logic [31:0] hwdata, hrdata, junk;
    logic cp, hr, completion_flag, fault_flag, irq;
    int num_errors = 0;
    int compares = 0;
    int done_seen = 0;
    assign hready = hreadyout;
    hspc_counter #(.PLAIN_CYC(4)) dut (.hclk, .hresetn, .hsel, .haddr,
        .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout,
        .hresp, .count_pulse_in(cp), .hard_reset_in(hr), .completion_flag,
        .fault_flag, .plain_inputs, .irq);
    hspc_pulse_src src (.hclk, .count_pulse_in(cp), .hard_reset_in(hr));
    initial hclk = 1'b0;
    always #10 hclk = ~hclk;
    // Completion pulses seen on the pin, one count per high cycle
    always @(posedge hclk) begin
        if (completion_flag === 1'b1) begin
            done_seen++;
        end
    end
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d,
             output logic [31:0] r);
        hsel <= 1'b1; haddr <= a; htrans <= 2'b10; hwrite <= w;
        hsize <= 3'b010;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0; htrans <= 2'b00; hwdata <= d;
        hsize <= 3'b000;
        do @(posedge hclk); while (hready !== 1'b1);
        r = hrdata;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d, junk);
    endtask
    task rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0000_0000, junk);
        `CHK(nm, e, junk)
    endtask
    task t_reset;
        rchk("ctrl", HSPC_OFF_CTRL, 32'h0000_0000);
        rchk("count", HSPC_OFF_COUNT, 32'h0000_0000);
        rchk("status", HSPC_OFF_STATUS, 32'h0000_0000);
        rchk("unmapped", 8'h18, 32'h0000_0000);
    endtask
    task t_count;
        wr(HSPC_OFF_TARGET, 32'h0000_0005);
        wr(HSPC_OFF_MASK, 32'h0000_0001);
        wr(HSPC_OFF_CTRL, 32'h0000_0003);
        src.pulses(3);
        rchk("count", HSPC_OFF_COUNT, 32'h0000_0003);
        src.pulses(2);
        rchk("count", HSPC_OFF_COUNT, 32'h0000_0000);
        rchk("done", HSPC_OFF_STATUS, 32'h0000_0001);
        `CHK("done pulses", 1, done_seen)
        `CHK("irq", 1'b1, irq)
        wr(HSPC_OFF_MASK, 32'h0000_0000);
        @(posedge hclk);
        `CHK("irq masked", 1'b0, irq)
        wr(HSPC_OFF_MASK, 32'h0000_0001);
        wr(HSPC_OFF_STATUS, 32'h0000_0001);
        @(posedge hclk);
        `CHK("irq cleared", 1'b0, irq)
        wr(HSPC_OFF_TARGET, 32'h0000_0012);
        src.pulses(10);
        rchk("bcd carry", HSPC_OFF_COUNT, 32'h0000_0010);
    endtask
    task t_gate;
        wr(HSPC_OFF_CTRL, 32'h0000_0001);
        src.pulses(3);
        rchk("gated", HSPC_OFF_COUNT, 32'h0000_0010);
        wr(HSPC_OFF_CTRL, 32'h0000_0003);
        src.pulses(1);
        rchk("resumed", HSPC_OFF_COUNT, 32'h0000_0011);
    endtask
    task t_hrst;
        src.pins(1'b0, 1'b1);
        rchk("hard reset", HSPC_OFF_COUNT, 32'h0000_0000);
        src.pulses(2);
        rchk("held", HSPC_OFF_COUNT, 32'h0000_0000);
        src.pins(1'b0, 1'b0);
        src.pulses(2);
        rchk("from zero", HSPC_OFF_COUNT, 32'h0000_0002);
    endtask
    task t_fault;
        wr(HSPC_OFF_TARGET, 32'h0000_000A);
        @(posedge hclk);
        `CHK("fault", 1'b1, fault_flag)
        rchk("fault bit", HSPC_OFF_STATUS, 32'h0000_0002);
        wr(HSPC_OFF_TARGET, 32'h0000_0000);
        wr(HSPC_OFF_STATUS, 32'h0000_0002);
        `CHK("fault gone", 1'b0, fault_flag)
        rchk("fault clear", HSPC_OFF_STATUS, 32'h0000_0000);
    endtask
    task t_wrap;
        src.pins(1'b0, 1'b1);
        src.pins(1'b0, 1'b0);
        src.pulses(9999);
        rchk("top", HSPC_OFF_COUNT, 32'h0000_9999);
        src.pulses(1);
        rchk("wrap", HSPC_OFF_COUNT, 32'h0000_0000);
        rchk("wrap done", HSPC_OFF_STATUS, 32'h0000_0001);
        `CHK("wrap pulses", 2, done_seen)
    endtask
    task t_plain;
        wr(HSPC_OFF_CTRL, 32'h0000_0000);
        src.pins(1'b1, 1'b1);
        src.pins(1'b1, 1'b1);
        `CHK("plain", 2'b11, plain_inputs)
        rchk("inputs", HSPC_OFF_INPUTS, 32'h0000_0003);
        wr(HSPC_OFF_CTRL, 32'h0000_0001);
        repeat (2) @(posedge hclk);
        `CHK("dedicated", 2'b00, plain_inputs)
    endtask
    task results;
        $display("Errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        hresetn = 1'b0; hsel = 1'b0; haddr = 8'h00; htrans = 2'b00;
        hwrite = 1'b0; hsize = 3'b000; hwdata = 32'h0000_0000;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_reset;
        t_count;
        t_gate;
        t_hrst;
        t_fault;
        t_wrap;
        t_plain;
        results;
    end
    // About 40k cycles expected; margin for a slow answer
    initial begin
        repeat (60000) @(posedge hclk);
        num_errors++;
        $display("Error watchdog expired");
        results;
    end
endmodule
